/* File: slosc_regs.svh */
// Constants of the serial link ordered-set codec
`ifndef SLOSC_REGS_SVH
`define SLOSC_REGS_SVH

// ****************************************************************
// Ordered-set octets (sent with the K flag)
// ****************************************************************
`define SLOSC_OCT_IDLE    8'hBC
`define SLOSC_OCT_EOP     8'hFD
`define SLOSC_OCT_BDIS    8'hF7
`define SLOSC_OCT_LINK    8'hFE
`define SLOSC_OCT_FCEN    8'h1C
`define SLOSC_OCT_FCDIS   8'h5C
`define SLOSC_OCT_ERR     8'h3C
`define SLOSC_OCT_INIT_FIRST  8'h9C
`define SLOSC_OCT_INIT_SECOND 8'hDC

// ****************************************************************
// Version byte, reset values and timing counts
// ****************************************************************
`define SLOSC_VER2_ID     8'h20
`define SLOSC_CG_RESET    10'h0FA
`define SLOSC_RD_RESET    1'b1
`define SLOSC_LINK_PERIOD 1024

`endif

/* File: slosc_pkg.sv */
// Types shared by both ends of the ordered-set codec
`default_nettype none
package slosc_pkg;

  // One 10-bit code group on the wire, bit 9 first ("abcdei fghj")
  typedef logic [9:0] slosc_cg_t;

  // Transmit sequencer states
  typedef enum logic [2:0] {
    ST_INIT_FIRST  = 3'b000,
    ST_VER0        = 3'b001,
    ST_INIT_SECOND = 3'b010,
    ST_VER1        = 3'b011,
    ST_LINK        = 3'b100,
    ST_RUN         = 3'b101
  } slosc_st_t;

endpackage
`default_nettype wire

/* File: slosc_link_if.sv */
// Serial link between the two codec ends
`timescale 1ns/10ps
`default_nettype none
interface slosc_link_if;
  import slosc_pkg::*;

  // Code groups in each direction
  slosc_cg_t d2p;
  slosc_cg_t p2d;

  modport dev  (output d2p, input p2d);
  modport peer (input d2p, output p2d);
endinterface
`default_nettype wire

/* File: slosc_dev_end.sv */
// Codec core and the device end of the link
`timescale 1ns/10ps
`default_nettype none
`include "slosc_regs.svh"

module slosc_core #(
  parameter int unsigned LINK_PERIOD = `SLOSC_LINK_PERIOD,
  parameter bit          VER2        = 1'b1
) (
  // Clock and reset
  input  wire logic              I_MCLK,
  input  wire logic              I_ARST_N,
  // Link symbols
  input  wire slosc_pkg::slosc_cg_t I_RX_SYM,
  output var  slosc_pkg::slosc_cg_t O_TX_SYM,
  // Transmit byte stream
  input  wire logic              I_TX_VALID,
  input  wire logic [7:0]        I_TX_BYTE,
  input  wire logic              I_TX_MASK,
  input  wire logic              I_TX_LAST,
  output logic                   O_TX_READY,
  // Local status and requests
  input  wire logic              I_RXF_FULL,
  input  wire logic              I_PKT_ERR,
  input  wire logic              I_INIT_REQ,
  // Receive byte stream and events
  output logic                   O_RX_VALID,
  output logic [7:0]             O_RX_BYTE,
  output logic                   O_RX_WE,
  output logic                   O_RX_EOP,
  output logic                   O_RX_ERR,
  output logic                   O_CODE_ERR,
  output logic                   O_LINK_UP,
  output logic                   O_PEER_V2
);
  import slosc_pkg::*;

  localparam int unsigned LTW = (LINK_PERIOD > 1) ? $clog2(LINK_PERIOD) : 1;
  localparam logic [LTW-1:0] LT_MAX = LTW'(LINK_PERIOD - 1);

  // Refuse a link period the timer cannot count
  if (LINK_PERIOD < 2) begin : g_chk
    $error("LINK_PERIOD must be at least 2");
  end

  // ****************************************************************
  // Code tables
  // ****************************************************************
  // 5b/6b data codes, negative running disparity form
  localparam logic [5:0] TBL6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  // 3b/4b data codes, negative running disparity form
  localparam logic [3:0] TBL4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  // Count of ones in a group
  function automatic logic [3:0] slosc_ones(input logic [9:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 10; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // Octet is one of the twelve control codes
  function automatic logic slosc_is_k(input logic [7:0] d);
    return (d[4:0] == 5'h1C) || (d inside {8'hF7, 8'hFB, 8'hFD, 8'hFE});
  endfunction

  // Encode an octet in the form the running disparity calls for
  function automatic slosc_cg_t slosc_enc(input logic k, input logic [7:0] d,
                                          input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic       rd6;
    logic       alt;
    slosc_cg_t  r;
    s6  = TBL6[d[4:0]];
    s4  = TBL4[d[7:5]];
    rd6 = rd;
    alt = 1'b0;
    r   = 10'h000;
    if (k) begin
      unique case (d)
        8'h1C:   r = 10'h0F4;
        8'h3C:   r = 10'h0F9;
        8'h5C:   r = 10'h0F5;
        8'h7C:   r = 10'h0F3;
        8'h9C:   r = 10'h0F2;
        8'hBC:   r = 10'h0FA;
        8'hDC:   r = 10'h0F6;
        8'hFC:   r = 10'h0F8;
        8'hF7:   r = 10'h3A8;
        8'hFB:   r = 10'h368;
        8'hFD:   r = 10'h2E8;
        8'hFE:   r = 10'h1E8;
        default: r = 10'h0FA;
      endcase
      if (rd) begin
        r = ~r;
      end
    end else begin
      // Unbalanced codes and D.7 flip under positive disparity
      if (rd && ((slosc_ones({4'h0, s6}) != 4'h3) || (d[4:0] == 5'h07))) begin
        s6 = ~s6;
      end
      rd6 = (slosc_ones({4'h0, s6}) != 4'h3) ? ~rd : rd;
      alt = (d[7:5] == 3'h7) &&
            ((!rd6 && (d[4:0] inside {5'h11, 5'h12, 5'h14})) ||
             (rd6 && (d[4:0] inside {5'h0B, 5'h0D, 5'h0E})));
      if (alt) begin
        s4 = 4'h7;
      end
      if (rd6 && (d[7:5] inside {3'h0, 3'h3, 3'h4, 3'h7})) begin
        s4 = ~s4;
      end
      r = {s6, s4};
    end
    return r;
  endfunction

  // Decode a group: {valid, k, octet}
  function automatic logic [9:0] slosc_dec(input slosc_cg_t s);
    logic [9:0] r;
    r = 10'h000;
    for (int i = 0; i < 512; i++) begin
      if ((!i[8] || slosc_is_k(i[7:0])) &&
          ((slosc_enc(i[8], i[7:0], 1'b0) == s) ||
           (slosc_enc(i[8], i[7:0], 1'b1) == s))) begin
        r = {1'b1, i[8], i[7:0]};
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  slosc_st_t      st_reg,       st_next;
  slosc_cg_t      tx_sym_reg,   tx_sym_next;
  logic           rd_reg,       rd_next;
  logic           ready_reg,    ready_next;
  logic           eop_pend_reg, eop_pend_next;
  logic           err_pend_reg, err_pend_next;
  logic           fc_sent_reg,  fc_sent_next;
  logic           fc_peer_reg,  fc_peer_next;
  logic [LTW-1:0] ltmr_reg,     ltmr_next;
  logic           lexp_reg,     lexp_next;
  logic           link_up_reg,  link_up_next;
  logic           peer_v2_reg,  peer_v2_next;
  logic           exp_ver_reg,  exp_ver_next;
  logic           rx_valid_reg, rx_valid_next;
  logic [7:0]     rx_byte_reg,  rx_byte_next;
  logic           rx_we_reg,    rx_we_next;
  logic           rx_eop_reg,   rx_eop_next;
  logic           rx_err_reg,   rx_err_next;
  logic           cerr_reg,     cerr_next;
  logic [9:0]     dec;
  logic           err_new;
  logic           tx_k;
  logic [7:0]     tx_oct;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Receive decode, then transmit arbitration
  always_comb begin
    st_next       = st_reg;
    eop_pend_next = eop_pend_reg;
    fc_sent_next  = fc_sent_reg;
    fc_peer_next  = fc_peer_reg;
    link_up_next  = link_up_reg;
    peer_v2_next  = peer_v2_reg;
    exp_ver_next  = 1'b0;
    rx_valid_next = 1'b0;
    rx_byte_next  = rx_byte_reg;
    rx_we_next    = 1'b0;
    rx_eop_next   = 1'b0;
    rx_err_next   = 1'b0;
    cerr_next     = 1'b0;
    err_new       = I_PKT_ERR;
    tx_k          = 1'b1;
    tx_oct        = `SLOSC_OCT_IDLE;
    dec           = slosc_dec(I_RX_SYM);
    // Receive side
    if (!dec[9]) begin
      cerr_next = 1'b1;
      err_new   = 1'b1;
    end else if (dec[8]) begin
      unique case (dec[7:0])
        `SLOSC_OCT_EOP:   rx_eop_next  = link_up_reg;
        `SLOSC_OCT_BDIS: begin
          rx_valid_next = link_up_reg;
          rx_we_next    = 1'b0;
        end
        `SLOSC_OCT_FCEN:  fc_peer_next = 1'b1;
        `SLOSC_OCT_FCDIS: fc_peer_next = 1'b0;
        `SLOSC_OCT_ERR:   rx_err_next  = 1'b1;
        `SLOSC_OCT_INIT_FIRST, `SLOSC_OCT_INIT_SECOND: begin
          exp_ver_next = 1'b1;
          link_up_next = 1'b0;
        end
        `SLOSC_OCT_LINK:  link_up_next = (st_reg == ST_RUN);
        default: ;
      endcase
      if (exp_ver_reg) begin
        peer_v2_next = 1'b0;
      end
    end else if (exp_ver_reg) begin
      peer_v2_next = (dec[7:0] == `SLOSC_VER2_ID);
    end else begin
      rx_valid_next = link_up_reg;
      rx_byte_next  = dec[7:0];
      rx_we_next    = 1'b1;
    end
    // Link timer keeps running; expiry is sticky until sent
    ltmr_next     = (ltmr_reg == LT_MAX) ? '0 : LTW'(ltmr_reg + 1'b1);
    lexp_next     = lexp_reg | (ltmr_reg == LT_MAX);
    err_pend_next = err_pend_reg | err_new;
    // Transmit side
    unique case (st_reg)
      ST_INIT_FIRST: begin
        tx_oct  = `SLOSC_OCT_INIT_FIRST;
        st_next = VER2 ? ST_VER0 : ST_INIT_SECOND;
      end
      ST_VER0: begin
        tx_k    = 1'b0;
        tx_oct  = `SLOSC_VER2_ID;
        st_next = ST_INIT_SECOND;
      end
      ST_INIT_SECOND: begin
        tx_oct  = `SLOSC_OCT_INIT_SECOND;
        st_next = VER2 ? ST_VER1 : ST_LINK;
      end
      ST_VER1: begin
        tx_k    = 1'b0;
        tx_oct  = `SLOSC_VER2_ID;
        st_next = ST_LINK;
      end
      ST_LINK: begin
        tx_oct  = `SLOSC_OCT_LINK;
        st_next = ST_RUN;
      end
      ST_RUN: begin
        if (ready_reg && I_TX_VALID) begin
          tx_k          = I_TX_MASK;
          tx_oct        = I_TX_MASK ? `SLOSC_OCT_BDIS : I_TX_BYTE;
          eop_pend_next = I_TX_LAST;
        end else if (eop_pend_reg) begin
          tx_oct        = `SLOSC_OCT_EOP;
          eop_pend_next = 1'b0;
        end else if (err_pend_reg) begin
          tx_oct        = `SLOSC_OCT_ERR;
          err_pend_next = err_new;
        end else if (fc_sent_reg != I_RXF_FULL) begin
          fc_sent_next  = I_RXF_FULL;
          tx_oct        = I_RXF_FULL ? `SLOSC_OCT_FCEN
                                     : `SLOSC_OCT_FCDIS;
        end else if (lexp_reg) begin
          tx_oct        = `SLOSC_OCT_LINK;
          lexp_next     = (ltmr_reg == LT_MAX);
        end else begin
          tx_oct        = `SLOSC_OCT_IDLE;
        end
      end
      default: st_next = ST_INIT_FIRST;
    endcase
    if (I_INIT_REQ) begin
      st_next      = ST_INIT_FIRST;
      link_up_next = 1'b0;
    end
    tx_sym_next = slosc_enc(tx_k, tx_oct, rd_reg);
    rd_next     = (slosc_ones(tx_sym_next) != 4'h5) ? ~rd_reg : rd_reg;
    // Data is offered only when nothing else waits and the peer allows it
    ready_next  = (st_next == ST_RUN) && link_up_next && !fc_peer_next &&
                  !eop_pend_next && !err_pend_next && !lexp_next &&
                  (fc_sent_next == I_RXF_FULL);
  end

  // Register all state
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_reg       <= ST_INIT_FIRST;
      tx_sym_reg   <= `SLOSC_CG_RESET;
      rd_reg       <= `SLOSC_RD_RESET;
      ready_reg    <= 1'b0;
      eop_pend_reg <= 1'b0;
      err_pend_reg <= 1'b0;
      fc_sent_reg  <= 1'b0;
      fc_peer_reg  <= 1'b0;
      ltmr_reg     <= '0;
      lexp_reg     <= 1'b0;
      link_up_reg  <= 1'b0;
      peer_v2_reg  <= 1'b0;
      exp_ver_reg  <= 1'b0;
      rx_valid_reg <= 1'b0;
      rx_byte_reg  <= 8'h00;
      rx_we_reg    <= 1'b0;
      rx_eop_reg   <= 1'b0;
      rx_err_reg   <= 1'b0;
      cerr_reg     <= 1'b0;
    end else begin
      st_reg       <= st_next;
      tx_sym_reg   <= tx_sym_next;
      rd_reg       <= rd_next;
      ready_reg    <= ready_next;
      eop_pend_reg <= eop_pend_next;
      err_pend_reg <= err_pend_next;
      fc_sent_reg  <= fc_sent_next;
      fc_peer_reg  <= fc_peer_next;
      ltmr_reg     <= ltmr_next;
      lexp_reg     <= lexp_next;
      link_up_reg  <= link_up_next;
      peer_v2_reg  <= peer_v2_next;
      exp_ver_reg  <= exp_ver_next;
      rx_valid_reg <= rx_valid_next;
      rx_byte_reg  <= rx_byte_next;
      rx_we_reg    <= rx_we_next;
      rx_eop_reg   <= rx_eop_next;
      rx_err_reg   <= rx_err_next;
      cerr_reg     <= cerr_next;
    end
  end

  // Outputs straight from flops
  assign O_TX_SYM   = tx_sym_reg;
  assign O_TX_READY = ready_reg;
  assign O_RX_VALID = rx_valid_reg;
  assign O_RX_BYTE  = rx_byte_reg;
  assign O_RX_WE    = rx_we_reg;
  assign O_RX_EOP   = rx_eop_reg;
  assign O_RX_ERR   = rx_err_reg;
  assign O_CODE_ERR = cerr_reg;
  assign O_LINK_UP  = link_up_reg;
  assign O_PEER_V2  = peer_v2_reg;
endmodule // slosc_core

module slosc_dev_end #(
  parameter int unsigned LINK_PERIOD = `SLOSC_LINK_PERIOD,
  parameter bit          VER2        = 1'b1
) (
  // Clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_ARST_N,
  // Link
  slosc_link_if.dev        LNK,
  // Transmit byte stream
  input  wire logic        I_TX_VALID,
  input  wire logic [7:0]  I_TX_BYTE,
  input  wire logic        I_TX_MASK,
  input  wire logic        I_TX_LAST,
  output logic             O_TX_READY,
  // Local status and requests
  input  wire logic        I_RXF_FULL,
  input  wire logic        I_PKT_ERR,
  input  wire logic        I_INIT_REQ,
  // Receive byte stream and events
  output logic             O_RX_VALID,
  output logic [7:0]       O_RX_BYTE,
  output logic             O_RX_WE,
  output logic             O_RX_EOP,
  output logic             O_RX_ERR,
  output logic             O_CODE_ERR,
  output logic             O_LINK_UP,
  output logic             O_PEER_V2
);
  // Device end drives d2p and hears p2d
  slosc_core #(.LINK_PERIOD(LINK_PERIOD), .VER2(VER2)) u_core (
    .I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N),
    .I_RX_SYM(LNK.p2d), .O_TX_SYM(LNK.d2p),
    .I_TX_VALID(I_TX_VALID), .I_TX_BYTE(I_TX_BYTE), .I_TX_MASK(I_TX_MASK),
    .I_TX_LAST(I_TX_LAST), .O_TX_READY(O_TX_READY),
    .I_RXF_FULL(I_RXF_FULL), .I_PKT_ERR(I_PKT_ERR), .I_INIT_REQ(I_INIT_REQ),
    .O_RX_VALID(O_RX_VALID), .O_RX_BYTE(O_RX_BYTE), .O_RX_WE(O_RX_WE),
    .O_RX_EOP(O_RX_EOP), .O_RX_ERR(O_RX_ERR), .O_CODE_ERR(O_CODE_ERR),
    .O_LINK_UP(O_LINK_UP), .O_PEER_V2(O_PEER_V2));
endmodule // slosc_dev_end
`default_nettype wire

/* File: slosc_peer_end.sv */
// Peer end of the link, the same codec facing the other way
`timescale 1ns/10ps
`default_nettype none
`include "slosc_regs.svh"

module slosc_peer_end #(
  parameter int unsigned LINK_PERIOD = `SLOSC_LINK_PERIOD,
  parameter bit          VER2        = 1'b1
) (
  // Clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_ARST_N,
  // Link
  slosc_link_if.peer       LNK,
  // Transmit byte stream
  input  wire logic        I_TX_VALID,
  input  wire logic [7:0]  I_TX_BYTE,
  input  wire logic        I_TX_MASK,
  input  wire logic        I_TX_LAST,
  output logic             O_TX_READY,
  // Local status and requests
  input  wire logic        I_RXF_FULL,
  input  wire logic        I_PKT_ERR,
  input  wire logic        I_INIT_REQ,
  // Receive byte stream and events
  output logic             O_RX_VALID,
  output logic [7:0]       O_RX_BYTE,
  output logic             O_RX_WE,
  output logic             O_RX_EOP,
  output logic             O_RX_ERR,
  output logic             O_CODE_ERR,
  output logic             O_LINK_UP,
  output logic             O_PEER_V2
);
  // Peer end drives p2d and hears d2p
  slosc_core #(.LINK_PERIOD(LINK_PERIOD), .VER2(VER2)) u_core (
    .I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N),
    .I_RX_SYM(LNK.d2p), .O_TX_SYM(LNK.p2d),
    .I_TX_VALID(I_TX_VALID), .I_TX_BYTE(I_TX_BYTE), .I_TX_MASK(I_TX_MASK),
    .I_TX_LAST(I_TX_LAST), .O_TX_READY(O_TX_READY),
    .I_RXF_FULL(I_RXF_FULL), .I_PKT_ERR(I_PKT_ERR), .I_INIT_REQ(I_INIT_REQ),
    .O_RX_VALID(O_RX_VALID), .O_RX_BYTE(O_RX_BYTE), .O_RX_WE(O_RX_WE),
    .O_RX_EOP(O_RX_EOP), .O_RX_ERR(O_RX_ERR), .O_CODE_ERR(O_CODE_ERR),
    .O_LINK_UP(O_LINK_UP), .O_PEER_V2(O_PEER_V2));
endmodule // slosc_peer_end
`default_nettype wire

/* File: slosc_link_monitor.sv */
// Wire checker for both directions of the ordered-set link
`timescale 1ns/10ps
`default_nettype none
module slosc_link_monitor #(
  parameter int unsigned LINK_PERIOD = 1024
) (
  // Clock and reset
  input  wire logic                 I_MCLK,
  input  wire logic                 I_ARST_N,
  // Code groups in each direction
  input  wire slosc_pkg::slosc_cg_t d2p,
  input  wire slosc_pkg::slosc_cg_t p2d
);
  import slosc_pkg::*;

  // ****************************************************************
  // Helper state
  // ****************************************************************
  localparam int unsigned GAP_MAX = LINK_PERIOD + 8;
  logic        rd_d_reg;
  logic        rd_d_next;
  logic        rd_p_reg;
  logic        rd_p_next;
  int unsigned gap_reg;
  int unsigned gap_next;

  // Any K28, end, or link group
  function automatic logic is_ctrl(input slosc_cg_t c);
    return (c[9:4] == 6'h0F) || (c[9:4] == 6'h30) ||
           (c inside {10'h2E8, 10'h117, 10'h1E8, 10'h217});
  endfunction

  // K28 groups must use a tabulated low nibble
  function automatic logic k28_ok(input slosc_cg_t c);
    if (c[9:4] == 6'h0F) return c[3:0] inside {4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'hA, 4'h6, 4'h8};
    if (c[9:4] == 6'h30) return c[3:0] inside {4'hB, 4'h6, 4'hA, 4'hC, 4'hD, 4'h5, 4'h9, 4'h7};
    return 1'b1;
  endfunction

  // Running disparity seen on the wire, gap since last link code
  always_comb begin
    rd_d_next = rd_d_reg;
    rd_p_next = rd_p_reg;
    gap_next = (d2p inside {10'h1E8, 10'h217}) ? 0 : gap_reg + 1;
    if ($countones(d2p) == 6) rd_d_next = 1'b1;
    if ($countones(d2p) == 4) rd_d_next = 1'b0;
    if ($countones(p2d) == 6) rd_p_next = 1'b1;
    if ($countones(p2d) == 4) rd_p_next = 1'b0;
  end

  // Reset idle on the wire counts as the first group
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rd_d_reg <= 1'b0;
      rd_p_reg <= 1'b0;
      gap_reg  <= 0;
    end else begin
      rd_d_reg <= rd_d_next;
      rd_p_reg <= rd_p_next;
      gap_reg  <= gap_next;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);

  dev_init_seq_a: assert property ($rose(I_ARST_N) |=> d2p == 10'h30D ##1 d2p == 10'h189
    ##1 d2p == 10'h0F6 ##1 d2p == 10'h189 ##1 d2p == 10'h1E8) else $error("dev init order wrong");
  peer_init_seq_a: assert property ($rose(I_ARST_N) |=> p2d == 10'h30D ##1 p2d == 10'h189
    ##1 p2d == 10'h0F6 ##1 p2d == 10'h189 ##1 p2d == 10'h1E8) else $error("peer init order wrong");
  dev_disp_a: assert property ($countones(d2p) inside {4, 5, 6} &&
    ($countones(d2p) != 6 || !rd_d_reg) && ($countones(d2p) != 4 || rd_d_reg))
    else $error("dev disparity broken");
  peer_disp_a: assert property ($countones(p2d) inside {4, 5, 6} &&
    ($countones(p2d) != 6 || !rd_p_reg) && ($countones(p2d) != 4 || rd_p_reg))
    else $error("peer disparity broken");
  dev_kform_a: assert property (k28_ok(d2p)) else $error("dev bad K28 group");
  peer_kform_a: assert property (k28_ok(p2d)) else $error("peer bad K28 group");
  dev_eop_data_a: assert property (d2p inside {10'h2E8, 10'h117} |-> !is_ctrl($past(d2p)))
    else $error("dev end code not after a byte");
  peer_eop_data_a: assert property (p2d inside {10'h2E8, 10'h117} |-> !is_ctrl($past(p2d)))
    else $error("peer end code not after a byte");
  link_timer_a: assert property (gap_reg <= GAP_MAX) else $error("link code overdue");
endmodule // slosc_link_monitor
`default_nettype wire

/* File: serial_link_ordered_set_codec_tb.sv */
// Bench joining both codec ends across one link
`timescale 1ns/10ps
`default_nettype none
module serial_link_ordered_set_codec_tb;
  import slosc_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int unsigned LP = 16;
  logic       clk, arst_n;
  logic       tx_valid [2], tx_mask [2], tx_last [2], rxf_full [2], pkt_err [2], init_req [2];
  logic [7:0] tx_byte [2], rx_byte [2];
  logic       tx_ready [2], rx_valid [2], rx_we [2], rx_eop [2], rx_err [2];
  logic       code_err [2], link_up [2], peer_v2 [2];
  int         fail_count, checks_done, cerrs, d_hits [1024], p_hits [1024], errs [2];
  logic [9:0] rxq [2][$], expq [2][$];

  slosc_link_if lnk ();

  // Both ends
  slosc_dev_end #(.LINK_PERIOD(LP)) slosc_dev_end_i (.I_MCLK(clk), .I_ARST_N(arst_n),
    .LNK(lnk), .I_TX_VALID(tx_valid[0]), .I_TX_BYTE(tx_byte[0]), .I_TX_MASK(tx_mask[0]),
    .I_TX_LAST(tx_last[0]), .O_TX_READY(tx_ready[0]), .I_RXF_FULL(rxf_full[0]),
    .I_PKT_ERR(pkt_err[0]), .I_INIT_REQ(init_req[0]), .O_RX_VALID(rx_valid[0]),
    .O_RX_BYTE(rx_byte[0]), .O_RX_WE(rx_we[0]), .O_RX_EOP(rx_eop[0]), .O_RX_ERR(rx_err[0]),
    .O_CODE_ERR(code_err[0]), .O_LINK_UP(link_up[0]), .O_PEER_V2(peer_v2[0]));
  slosc_peer_end #(.LINK_PERIOD(LP)) slosc_peer_end_i (.I_MCLK(clk), .I_ARST_N(arst_n),
    .LNK(lnk), .I_TX_VALID(tx_valid[1]), .I_TX_BYTE(tx_byte[1]), .I_TX_MASK(tx_mask[1]),
    .I_TX_LAST(tx_last[1]), .O_TX_READY(tx_ready[1]), .I_RXF_FULL(rxf_full[1]),
    .I_PKT_ERR(pkt_err[1]), .I_INIT_REQ(init_req[1]), .O_RX_VALID(rx_valid[1]),
    .O_RX_BYTE(rx_byte[1]), .O_RX_WE(rx_we[1]), .O_RX_EOP(rx_eop[1]), .O_RX_ERR(rx_err[1]),
    .O_CODE_ERR(code_err[1]), .O_LINK_UP(link_up[1]), .O_PEER_V2(peer_v2[1]));
  slosc_link_monitor #(.LINK_PERIOD(LP)) slosc_link_monitor_i (.I_MCLK(clk),
    .I_ARST_N(arst_n), .d2p(lnk.d2p), .p2d(lnk.p2d));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Wire tallies and receive capture, mid-cycle where outputs are settled
  always @(negedge clk) begin
    if (arst_n === 1'b1) begin
      d_hits[lnk.d2p]++;
      p_hits[lnk.p2d]++;
      for (int e = 0; e < 2; e++) begin
        if (rx_valid[e] === 1'b1) rxq[e].push_back({1'b0, rx_we[e], rx_byte[e]});
        if (rx_eop[e] === 1'b1) rxq[e].push_back(10'h200);
        if (rx_err[e] === 1'b1) errs[e]++;
        if (code_err[e] === 1'b1) cerrs++;
      end
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  function automatic int hits(input bit p, input logic [9:0] a, input logic [9:0] b);
    return p ? p_hits[a] + p_hits[b] : d_hits[a] + d_hits[b];
  endfunction

  task automatic clr();
    d_hits = '{default: 0};
    p_hits = '{default: 0};
    errs = '{default: 0};
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Offer bytes on end e, each held until ready is seen
  task automatic send(input int e, input int n, input logic [63:0] dat, input logic [7:0] msk);
    int w;
    for (int k = 0; k < n; k++) begin
      tx_valid[e] = 1'b1;
      tx_byte[e] = dat[8*k +: 8];
      tx_mask[e] = msk[k];
      tx_last[e] = (k == n - 1);
      w = 0;
      while (tx_ready[e] !== 1'b1 && w < 300) begin
        tick(1);
        w++;
      end
      check("ready wait", w < 300, 1);
      tick(1);
      expq[1-e].push_back(msk[k] ? 10'h000 : {2'b01, dat[8*k +: 8]});
    end
    tx_valid[e] = 1'b0;
    tx_last[e] = 1'b0;
    expq[1-e].push_back(10'h200);
  endtask

  // Compare what end e received; masked slots compare write enable only
  task automatic drain(input int e);
    logic [9:0] s;
    logic [9:0] x;
    tick(8);
    check("rx count", rxq[e].size(), expq[e].size());
    while (rxq[e].size() > 0 && expq[e].size() > 0) begin
      s = rxq[e].pop_front();
      x = expq[e].pop_front();
      check("rx slot", (x == 10'h000) ? (s & 10'h300) : s, x);
    end
    rxq[e].delete();
    expq[e].delete();
  endtask

  task automatic wait_up();
    int w;
    w = 0;
    while (!(link_up[0] === 1'b1 && link_up[1] === 1'b1) && w < 200) begin
      tick(1);
      w++;
    end
    check("link up", w < 200, 1);
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(3000 * 100);
    fail_count++;
    test_done();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    arst_n = 1'b0;
    fail_count = 0;
    checks_done = 0;
    cerrs = 0;
    for (int e = 0; e < 2; e++) begin
      tx_valid[e] = 1'b0;
      tx_byte[e] = 8'h00;
      tx_mask[e] = 1'b0;
      tx_last[e] = 1'b0;
      rxf_full[e] = 1'b0;
      pkt_err[e] = 1'b0;
      init_req[e] = 1'b0;
    end
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    wait_up();
    check("dev sees version", peer_v2[0], 1);
    check("peer sees version", peer_v2[1], 1);
    // Masked write, then two packets back to back the other way
    clr();
    send(0, 4, 64'h44332211, 8'h04);
    drain(1);
    check("mask groups", hits(0, 10'h3A8, 10'h057), 1);
    check("dev end groups", hits(0, 10'h2E8, 10'h117), 1);
    clr();
    send(1, 3, 64'hC0FFEE, 8'h00);
    tick(1);
    send(1, 1, 64'h5A, 8'h00);
    drain(0);
    check("peer end groups", hits(1, 10'h2E8, 10'h117), 2);
    // Peer FIFO fills: dev must hold its data and fill with idle and link codes
    clr();
    rxf_full[1] = 1'b1;
    tick(4);
    check("flow enable groups", hits(1, 10'h0F4, 10'h30B), 1);
    check("dev ready flowed", tx_ready[0], 0);
    fork
      send(0, 2, 64'hBEEF, 8'h00);
    join_none
    tick(30);
    check("flowed bytes", rxq[1].size(), 0);
    check("flowed fill", hits(0, 10'h0FA, 10'h305) + hits(0, 10'h1E8, 10'h217), 34);
    rxf_full[1] = 1'b0;
    wait fork;
    drain(1);
    check("flow disable groups", hits(1, 10'h0F5, 10'h30A), 1);
    // Error indication reaches the peer
    clr();
    pkt_err[0] = 1'b1;
    tick(1);
    pkt_err[0] = 1'b0;
    tick(6);
    check("error groups", hits(0, 10'h0F9, 10'h306), 1);
    check("peer error pulses", errs[1], 1);
    // Quiet link: idle fill and periodic link codes
    clr();
    tick(64);
    check("link groups", hits(0, 10'h1E8, 10'h217), 4);
    check("idle groups", hits(0, 10'h0FA, 10'h305), 60);
    // Restart initialisation from the dev end
    init_req[0] = 1'b1;
    tick(1);
    init_req[0] = 1'b0;
    tick(2);
    check("link dropped", link_up[0], 0);
    wait_up();
    check("version again", peer_v2[1], 1);
    check("code errors", cerrs, 0);
    test_done();
  end
endmodule // serial_link_ordered_set_codec_tb
`default_nettype wire
